// File: hw/pwc_pkg.sv
// What this block does
// RQ1 - Pause flow control on only after negotiation done, full duplex, pause chosen.
// RQ2 - Control frame recognised only by its Length/Type field.
// RQ3 - Only control opcode 0001h is acted on as a pause request.
// RQ4 - Pause time is a 16-bit unsigned count of slot times, 0 to 65535.
// RQ5 - Sender addresses pause to reserved multicast or our unicast address.
// RQ6 - Valid pause loads timer; paused state ends when timer reaches zero.
// RQ7 - A frame already leaving the MAC completes; pause never cuts it.
// RQ8 - No new frame starts later than one slot after nonzero pause.
// RQ9 - Pause time of zero ends paused state at once.
// RQ10 - Timer steps once per slot time; new pause reloads timer.
// RQ11 - Wake frame: address passes filter, CRC good, 6 FF then 16 addresses.
// RQ12 - Any one complete sync-plus-addresses pattern in a frame is enough.
// RQ13 - Wake enable is config control bit 18, loaded from EEPROM, driver writable.
// RQ14 - Enabled wake frame drives event output low and sets status bit 15.
// RQ15 - Full duplex: collision ignored, carrier only while receiving.
// RQ16 - Half duplex: collision on overlap, carrier on transmit or receive.
// RQ17 - D1: configuration access only, context kept, only wake events signalled.
// RQ18 - D2: configuration access only, no transmit or receive, not even wake.
// RQ19 - Leaving D3hot for D0 does an internal reset to power-up state; here PME status is kept.
// RQ20 - D3hot still answers configuration cycles while power and clock remain.
package pwc_pkg;
  localparam logic [15:0] CTRL_LEN_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [47:0] PAUSE_MCAST = 48'h0180C2000001;
  localparam int SYNC_FF_COUNT = 6;
  localparam int ADDR_REPEATS = 16;
  localparam int WAKE_EN_BIT = 18;
  localparam int PME_STATUS_BIT = 15;
  // Register offsets of this block
  localparam logic [3:0] ADDR_CFG_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PM_STATUS = 4'h1;
  localparam logic [3:0] ADDR_STATION_LO = 4'h2;
  localparam logic [3:0] ADDR_STATION_HI = 4'h3;
  localparam logic [3:0] ADDR_PAUSE_STAT = 4'h4;
  localparam logic [31:0] CFG_CTRL_RST = 32'h0000_0000;
  // Slot time in ns at 100 Mb/s and 10 Mb/s (512 bit times)
  localparam int CLK_NS = 8;
  localparam int SLOT_NS_100 = 5120;
  localparam int SLOT_NS_10 = 51200;
  localparam int SLOT_CYC_100 = SLOT_NS_100 / CLK_NS;
  localparam int SLOT_CYC_10 = SLOT_NS_10 / CLK_NS;
  typedef enum logic [1:0] {PS_D0, PS_D1, PS_D2, PS_D3HOT} pwc_pstate_type;
  typedef enum {PR_DA, PR_SA, PR_TYPE, PR_OP, PR_TIME, PR_REST}
    pwc_prx_type;
endpackage

// File: hw/pwc_ctrl.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pwc_ctrl #(
  parameter int SLOT_CYC_10 = pwc_pkg::SLOT_CYC_10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // EEPROM recall of config control bits 31..16
  input wire logic eeprom_load,
  input wire logic [15:0] eeprom_data,
  // Link status from negotiation
  input wire logic an_done,
  input wire logic link_full_duplex,
  input wire logic link_pause,
  input wire logic link_100,
  // Power state from host
  input wire logic [1:0] power_state,
  // Receive byte stream
  input wire logic rx_active,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic rx_addr_ok,
  // Transmit handshake
  input wire logic tx_req,
  input wire logic tx_active,
  output logic tx_start,
  output logic paused,
  // Medium indications
  input wire logic phy_col,
  input wire logic phy_rx_crs,
  output logic mac_col,
  output logic mac_crs,
  // Power management
  output logic power_mgmt_event_n,
  output logic internal_rst,
  output logic net_rx_enable
);
  logic [31:0] cfg_r, cfg_nxt;
  logic pme_r, pme_nxt;
  logic [47:0] station_r, station_nxt;
  logic [15:0] timer_r, timer_nxt;
  logic [15:0] slot_cnt_r, slot_cnt_nxt;
  logic paused_r, paused_nxt;
  logic grace_r, grace_nxt;
  pwc_pkg::pwc_prx_type prx_r, prx_nxt;
  logic [5:0] pidx_r, pidx_nxt;
  logic [47:0] da_r, da_nxt;
  logic ctrl_ok_r, ctrl_ok_nxt;
  logic [15:0] ptime_r, ptime_nxt;
  logic op_ok_r, op_ok_nxt;
  logic [2:0] ff_cnt_r, ff_cnt_nxt;
  logic [6:0] wk_idx_r, wk_idx_nxt;
  logic wk_hit_r, wk_hit_nxt;
  logic [1:0] pst_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic pause_en, slot_tick, pause_ok, d3_exit, wake_ok;
  logic [15:0] slot_len;

  function automatic logic [7:0] addr_byte(input logic [47:0] a,
                                           input logic [6:0] i);
    logic [2:0] k;
    k = 3'(i % 7'h06);
    addr_byte = a[8'(47 - 8 * k) -: 8];
  endfunction

  assign pause_en = an_done && link_full_duplex && link_pause; // RQ1
  assign slot_len = link_100 ? 16'(pwc_pkg::SLOT_CYC_100)
                             : 16'(SLOT_CYC_10);
  assign slot_tick = (slot_cnt_r == 16'h0000);
  // Leaving D3hot resets everything but the pin-reset-only state
  assign d3_exit = (pst_r == 2'(pwc_pkg::PS_D3HOT))
    && (power_state == 2'(pwc_pkg::PS_D0)); // RQ19
  assign net_rx_enable = (power_state == 2'(pwc_pkg::PS_D0))
    || (power_state == 2'(pwc_pkg::PS_D1)); // RQ17 RQ18
  assign internal_rst = d3_exit;
  // Pause frame complete and good at end of reception
  assign pause_ok = rx_end && rx_crc_ok && ctrl_ok_r && op_ok_r
    && pause_en && net_rx_enable && (power_state == 2'(pwc_pkg::PS_D0))
    && ((da_r == pwc_pkg::PAUSE_MCAST) || (da_r == station_r));
  assign wake_ok = rx_end && rx_crc_ok && rx_addr_ok && wk_hit_r
    && cfg_r[pwc_pkg::WAKE_EN_BIT] && net_rx_enable; // RQ11 RQ13
  // Grace lets a queued frame start within one slot; in-flight never cut
  assign tx_start = tx_req && !tx_active
    && (power_state == 2'(pwc_pkg::PS_D0))
    && (!paused_r || grace_r); // RQ7 RQ8
  assign paused = paused_r;
  assign mac_col = link_full_duplex ? 1'b0 : phy_col; // RQ15 RQ16
  assign mac_crs = link_full_duplex ? phy_rx_crs
                                    : (phy_rx_crs || tx_active); // RQ15 RQ16
  assign power_mgmt_event_n = !pme_r; // RQ14
  assign reg_rdata = rdata_r;

  // Receive parser for pause and wake patterns
  always_comb begin
    prx_nxt = prx_r;
    pidx_nxt = pidx_r;
    da_nxt = da_r;
    ctrl_ok_nxt = ctrl_ok_r;
    op_ok_nxt = op_ok_r;
    ptime_nxt = ptime_r;
    ff_cnt_nxt = ff_cnt_r;
    wk_idx_nxt = wk_idx_r;
    wk_hit_nxt = wk_hit_r;
    if (!rx_active || rx_end) begin
      prx_nxt = pwc_pkg::PR_DA;
      pidx_nxt = 6'h00;
      ctrl_ok_nxt = 1'b0;
      op_ok_nxt = 1'b0;
      ff_cnt_nxt = 3'h0;
      wk_idx_nxt = 7'h00;
      wk_hit_nxt = 1'b0;
    end else if (rx_valid && net_rx_enable) begin
      case (prx_r)
        pwc_pkg::PR_DA: begin
          da_nxt = {da_r[39:0], rx_data};
          pidx_nxt = pidx_r + 6'h01;
          if (pidx_r == 6'h05) begin
            prx_nxt = pwc_pkg::PR_SA;
            pidx_nxt = 6'h00;
          end
        end
        pwc_pkg::PR_SA: begin
          pidx_nxt = pidx_r + 6'h01;
          if (pidx_r == 6'h05) begin
            prx_nxt = pwc_pkg::PR_TYPE;
            pidx_nxt = 6'h00;
          end
        end
        pwc_pkg::PR_TYPE: begin
          pidx_nxt = pidx_r + 6'h01;
          if (pidx_r == 6'h00) begin
            ctrl_ok_nxt = (rx_data == pwc_pkg::CTRL_LEN_TYPE[15:8]);
          end else begin
            ctrl_ok_nxt = ctrl_ok_r
              && (rx_data == pwc_pkg::CTRL_LEN_TYPE[7:0]); // RQ2
            prx_nxt = pwc_pkg::PR_OP;
            pidx_nxt = 6'h00;
          end
        end
        pwc_pkg::PR_OP: begin
          pidx_nxt = pidx_r + 6'h01;
          if (pidx_r == 6'h00) begin
            op_ok_nxt = (rx_data == pwc_pkg::PAUSE_OPCODE[15:8]);
          end else begin
            op_ok_nxt = op_ok_r
              && (rx_data == pwc_pkg::PAUSE_OPCODE[7:0]); // RQ3
            prx_nxt = pwc_pkg::PR_TIME;
            pidx_nxt = 6'h00;
          end
        end
        pwc_pkg::PR_TIME: begin
          ptime_nxt = {ptime_r[7:0], rx_data}; // RQ4
          pidx_nxt = pidx_r + 6'h01;
          if (pidx_r == 6'h01) begin
            prx_nxt = pwc_pkg::PR_REST;
          end
        end
        pwc_pkg::PR_REST: begin
        end
        default: prx_nxt = pwc_pkg::PR_DA;
      endcase
      // Wake pattern scan over the whole frame; run of FF may exceed six
      if (wk_idx_r != 7'h00) begin
        if (rx_data == addr_byte(station_r, wk_idx_r - 7'h01)) begin
          if (wk_idx_r == 7'(pwc_pkg::ADDR_REPEATS * 6)) begin
            wk_hit_nxt = 1'b1; // RQ12
            wk_idx_nxt = 7'h00;
          end else begin
            wk_idx_nxt = wk_idx_r + 7'h01;
          end
          ff_cnt_nxt = 3'h0;
        end else begin
          wk_idx_nxt = 7'h00;
          ff_cnt_nxt = (rx_data == 8'hFF) ? 3'h1 : 3'h0;
        end
      end else if (rx_data == 8'hFF) begin
        if (ff_cnt_r != 3'(pwc_pkg::SYNC_FF_COUNT)) begin
          ff_cnt_nxt = ff_cnt_r + 3'h1;
        end
      end else if (ff_cnt_r == 3'(pwc_pkg::SYNC_FF_COUNT)
                   && rx_data == addr_byte(station_r, 7'h00)) begin
        wk_idx_nxt = 7'h02; // RQ11
        ff_cnt_nxt = 3'h0;
      end else begin
        ff_cnt_nxt = 3'h0;
      end
    end
  end

  // Pause timer
  always_comb begin
    timer_nxt = timer_r;
    paused_nxt = paused_r;
    grace_nxt = grace_r;
    slot_cnt_nxt = slot_tick ? (slot_len - 16'h0001)
                             : (slot_cnt_r - 16'h0001);
    if (!pause_en) begin
      paused_nxt = 1'b0;
      timer_nxt = 16'h0000;
      grace_nxt = 1'b0;
    end else if (pause_ok) begin
      timer_nxt = ptime_r; // RQ6 RQ10
      paused_nxt = (ptime_r != 16'h0000); // RQ9
      grace_nxt = !paused_r && (ptime_r != 16'h0000);
      slot_cnt_nxt = slot_len - 16'h0001;
    end else if (paused_r && slot_tick) begin
      grace_nxt = 1'b0; // RQ8
      timer_nxt = timer_r - 16'h0001; // RQ10
      if (timer_r == 16'h0001) begin
        paused_nxt = 1'b0; // RQ6
      end
    end
  end

  // Registers and wake status
  always_comb begin
    cfg_nxt = cfg_r;
    pme_nxt = pme_r;
    station_nxt = station_r;
    rdata_nxt = 32'h0000_0000;
    if (eeprom_load) begin
      cfg_nxt[31:16] = eeprom_data; // RQ13
    end
    if (reg_wr) begin
      case (reg_addr)
        pwc_pkg::ADDR_CFG_CTRL: cfg_nxt = reg_wdata; // RQ13
        pwc_pkg::ADDR_PM_STATUS: begin
          if (reg_wdata[pwc_pkg::PME_STATUS_BIT]) begin
            pme_nxt = 1'b0;
          end
        end
        pwc_pkg::ADDR_STATION_LO: station_nxt[31:0] = reg_wdata;
        pwc_pkg::ADDR_STATION_HI: station_nxt[47:32] = reg_wdata[15:0];
        default: ;
      endcase
    end
    if (wake_ok) begin
      pme_nxt = 1'b1; // RQ14
    end
    if (reg_rd) begin
      case (reg_addr)
        pwc_pkg::ADDR_CFG_CTRL: rdata_nxt = cfg_r;
        pwc_pkg::ADDR_PM_STATUS:
          rdata_nxt[pwc_pkg::PME_STATUS_BIT] = pme_r;
        pwc_pkg::ADDR_STATION_LO: rdata_nxt = station_r[31:0];
        pwc_pkg::ADDR_STATION_HI: rdata_nxt = {16'h0000, station_r[47:32]};
        pwc_pkg::ADDR_PAUSE_STAT: rdata_nxt = {15'h0000, paused_r, timer_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Power state tracker survives internal reset so exit is seen once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pst_r <= 2'(pwc_pkg::PS_D0);
    end else begin
      pst_r <= power_state;
    end
  end

  // PME status is kept across the D3hot exit so the wake stays visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pme_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      pme_r <= pme_nxt;
      rdata_r <= rdata_nxt; // RQ20
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= pwc_pkg::CFG_CTRL_RST;
      station_r <= 48'h0000_0000_0000;
      timer_r <= 16'h0000;
      slot_cnt_r <= 16'h0000;
      paused_r <= 1'b0;
      grace_r <= 1'b0;
      prx_r <= pwc_pkg::PR_DA;
      pidx_r <= 6'h00;
      da_r <= 48'h0000_0000_0000;
      ctrl_ok_r <= 1'b0;
      op_ok_r <= 1'b0;
      ptime_r <= 16'h0000;
      ff_cnt_r <= 3'h0;
      wk_idx_r <= 7'h00;
      wk_hit_r <= 1'b0;
    end else if (d3_exit) begin
      cfg_r <= pwc_pkg::CFG_CTRL_RST; // RQ19
      station_r <= 48'h0000_0000_0000;
      timer_r <= 16'h0000;
      slot_cnt_r <= 16'h0000;
      paused_r <= 1'b0;
      grace_r <= 1'b0;
      prx_r <= pwc_pkg::PR_DA;
      pidx_r <= 6'h00;
      da_r <= 48'h0000_0000_0000;
      ctrl_ok_r <= 1'b0;
      op_ok_r <= 1'b0;
      ptime_r <= 16'h0000;
      ff_cnt_r <= 3'h0;
      wk_idx_r <= 7'h00;
      wk_hit_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      station_r <= station_nxt;
      timer_r <= timer_nxt;
      slot_cnt_r <= slot_cnt_nxt;
      paused_r <= paused_nxt;
      grace_r <= grace_nxt;
      prx_r <= prx_nxt;
      pidx_r <= pidx_nxt;
      da_r <= da_nxt;
      ctrl_ok_r <= ctrl_ok_nxt;
      op_ok_r <= op_ok_nxt;
      ptime_r <= ptime_nxt;
      ff_cnt_r <= ff_cnt_nxt;
      wk_idx_r <= wk_idx_nxt;
      wk_hit_r <= wk_hit_nxt;
    end
  end
endmodule
`default_nettype wire

// File: bench/pwc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_monitor #(
  parameter int SLOT_CYC_10 = 6400
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link, power, receive, transmit and medium inputs
  input wire logic an_done,
  input wire logic link_full_duplex,
  input wire logic link_pause,
  input wire logic [1:0] power_state,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  input wire logic rx_addr_ok,
  input wire logic tx_active,
  input wire logic phy_col,
  input wire logic phy_rx_crs,
  // Outputs watched
  input wire logic tx_start,
  input wire logic paused,
  input wire logic mac_col,
  input wire logic mac_crs,
  input wire logic power_mgmt_event_n,
  input wire logic internal_rst,
  input wire logic net_rx_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_full_col_off: assert property (
    link_full_duplex |-> !mac_col) else $error("col in full duplex");
  a_full_crs_rx: assert property (
    link_full_duplex |-> mac_crs == phy_rx_crs) else $error("full crs");
  a_half_crs_both: assert property (
    !link_full_duplex |-> mac_crs == (phy_rx_crs | tx_active))
    else $error("half crs");
  a_half_col_seen: assert property (
    !link_full_duplex && phy_col |-> mac_col) else $error("half col");
  a_busy_no_start: assert property (
    tx_active |-> !tx_start) else $error("start over busy frame");
  a_d2_net_off: assert property (
    power_state == 2'h2 |-> !tx_start && !net_rx_enable)
    else $error("network active in D2");
  a_d3_exit_rst: assert property (
    $past(power_state) == 2'h3 && power_state == 2'h0 |-> internal_rst)
    else $error("no internal reset");
  a_pause_gate: assert property (
    $rose(paused) |-> $past(an_done && link_full_duplex && link_pause))
    else $error("pause without negotiation");
  a_wake_cause: assert property (
    $fell(power_mgmt_event_n) |-> $past(rx_end && rx_crc_ok && rx_addr_ok))
    else $error("event without good frame");
  cover property ($rose(paused));
  cover property ($fell(power_mgmt_event_n));
  cover property (internal_rst);
endmodule
bind pwc_ctrl pwc_monitor #(.SLOT_CYC_10(SLOT_CYC_10)) u_mon (.clk, .rst,
  .an_done, .link_full_duplex, .link_pause, .power_state, .rx_end,
  .rx_crc_ok, .rx_addr_ok, .tx_active, .phy_col, .phy_rx_crs, .tx_start,
  .paused, .mac_col, .mac_crs, .power_mgmt_event_n, .internal_rst,
  .net_rx_enable);
`default_nettype wire

// File: bench/pwc_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pwc_link_partner #(
  parameter logic [47:0] STA = 48'h02A1B2C3D4E5
) (
  // Clock
  input wire logic clk,
  // Receive stream
  output logic rx_active,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_crc_ok,
  output logic rx_addr_ok
);
  logic [7:0] q[$];
  initial
    {rx_active, rx_valid, rx_data, rx_end, rx_crc_ok, rx_addr_ok} = '0;
  task automatic put(input logic [47:0] v);
    for (int i = 5; i >= 0; i--) q.push_back(v[i*8+:8]);
  endtask
  task automatic send(input logic crc);
    foreach (q[i]) begin
      @(posedge clk);
      {rx_active, rx_valid, rx_data} <= {2'b11, q[i]};
    end
    @(posedge clk);
    {rx_valid, rx_end, rx_crc_ok, rx_addr_ok} <= {2'b01, crc, 1'b1};
    // Idle line toggles so stale bytes never look valid
    rx_data <= ~rx_data;
    @(posedge clk);
    {rx_active, rx_end, rx_crc_ok, rx_addr_ok} <= 4'h0;
    q.delete();
  endtask
  task automatic pause(input logic [15:0] op, input logic [15:0] t);
    put(48'h0180C2000001);
    put(STA ^ 48'h1);
    put({pwc_pkg::CTRL_LEN_TYPE, op, t});
    put('0);
    send(1'b1);
  endtask
  task automatic wake(input logic crc);
    put(STA);
    put(STA ^ 48'h1);
    put(48'h0800FFFFFFFF);
    put('1);
    repeat (16) put(STA);
    send(crc);
  endtask
endmodule
`default_nettype wire

// File: bench/pause_and_wake_frame_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pause_and_wake_frame_ctrl_tb;
  localparam int SLOT = 16;
  localparam logic [47:0] STA = 48'h02A1B2C3D4E5;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, eeprom_load = 0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, rd;
  logic [15:0] eeprom_data = '0;
  logic an_done = 1, link_full_duplex = 1, link_pause = 1, link_100 = 0;
  logic [1:0] power_state = '0;
  logic rx_active, rx_valid, rx_end, rx_crc_ok, rx_addr_ok;
  logic [7:0] rx_data;
  logic tx_req = 0, tx_active = 0, phy_col = 0, phy_rx_crs = 0;
  logic tx_start, paused, mac_col, mac_crs, power_mgmt_event_n;
  logic internal_rst, net_rx_enable;
  int miscompares = 0, n_tests = 0, t;
  pwc_ctrl #(.SLOT_CYC_10(SLOT)) u_dut (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .eeprom_load, .eeprom_data, .an_done,
    .link_full_duplex, .link_pause, .link_100, .power_state, .rx_active,
    .rx_valid, .rx_data, .rx_end, .rx_crc_ok, .rx_addr_ok, .tx_req,
    .tx_active, .tx_start, .paused, .phy_col, .phy_rx_crs, .mac_col,
    .mac_crs, .power_mgmt_event_n, .internal_rst, .net_rx_enable);
  pwc_link_partner #(.STA(STA)) u_lp (.clk, .rx_active, .rx_valid,
    .rx_data, .rx_end, .rx_crc_ok, .rx_addr_ok);
  always #4 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, string m);
    @(posedge clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, m);
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    void'($urandom(62));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdc(4'h0, '0, "cfg reset");
    rdc(4'h1, '0, "pm reset");
    rd = $urandom();
    wr(4'h0, rd);
    rdc(4'h0, rd, "cfg rw");
    rdc(4'h5, '0, "unmapped");
    @(posedge clk);
    {eeprom_load, eeprom_data} <= {1'b1, 16'h0004};
    @(posedge clk);
    eeprom_load <= 1'b0;
    rdc(4'h0, {16'h0004, rd[15:0]}, "eeprom recall");
    wr(4'h2, STA[31:0]);
    wr(4'h3, {16'h0, STA[47:32]});
    $display("registers done");
    // Model: timer holds t slots, grace lasts one slot
    t = 2 + $urandom_range(3);
    u_lp.pause(pwc_pkg::PAUSE_OPCODE, t[15:0]);
    #1 chk(paused, 1, "pause on");
    rdc(4'h4, {15'h0, 1'b1, t[15:0]}, "timer load");
    @(posedge clk);
    tx_req <= 1'b1;
    repeat (SLOT + 2) @(posedge clk);
    #1 chk(tx_start, 0, "held after slot");
    // Lands one cycle before the last slot ends, so early release is caught
    repeat (t * SLOT - SLOT - 6) @(posedge clk);
    #1 chk(paused, 1, "held to last slot");
    @(posedge clk);
    #1 chk({paused, tx_start}, 2'b01, "resume");
    @(posedge clk);
    tx_req <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      link_full_duplex <= i != 3;
      u_lp.pause(i == 2 ? 16'h0002 : pwc_pkg::PAUSE_OPCODE,
        i == 1 ? 16'h0 : 16'h0028);
      #1 chk(paused, i == 0, "pause table");
    end
    $display("pause done");
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {link_full_duplex, phy_col, phy_rx_crs, tx_active} <= 4'(i);
      @(negedge clk);
      chk({mac_col, mac_crs}, i[3] ? {1'b0, i[1]} : {i[2], i[1] | i[0]},
        "medium");
    end
    $display("medium done");
    u_lp.wake(1'b0);
    #1 chk(power_mgmt_event_n, 1, "bad crc wake");
    @(posedge clk);
    power_state <= 2'h2;
    u_lp.wake(1'b1);
    #1 chk({power_mgmt_event_n, net_rx_enable}, 2'b10, "D2");
    @(posedge clk);
    power_state <= 2'h1;
    u_lp.wake(1'b1);
    #1 chk(power_mgmt_event_n, 0, "wake");
    @(posedge clk);
    power_state <= 2'h3;
    @(posedge clk);
    power_state <= 2'h0;
    #1 chk(internal_rst, 1, "leave D3hot");
    rdc(4'h0, '0, "cfg after D3hot");
    rdc(4'h1, 32'h0000_8000, "event status");
    wr(4'h1, 32'h0000_8000);
    #1 chk(power_mgmt_event_n, 1, "event cleared");
    $display("power done");
    give_verdict();
  end
endmodule
`default_nettype wire
